// >>> rtc_supply_osc_status_detect.sv
// power-on, oscillator-stop and battery-drop detection with the control registers
// assumes detector levels arrive asynchronously and sec_tick is a core_clk pulse
//
// Operation
// RULE1: power-on from zero sets power-on flag
// RULE2: write zero clears power-on flag, one ignored
// RULE3: power-on flag sticks until software clears
// RULE4: power-on flag forces listed register bits zero
// RULE5: power-on releases both interrupt pins
// RULE6: power-on defaults: control-2 70h, others zero
// RULE7: read-only bits read zero, writes dropped
// RULE8: software initialises other registers after power-on
// RULE9: oscillator stop clears oscillator flag, held
// RULE10: writes to oscillator flag have no effect
// RULE11: battery drop sets battery-drop flag
// RULE12: write zero clears battery flag, restarts monitor
// RULE13: battery sampled 7.8 ms each second
// RULE14: sampling halts while battery flag set
// RULE15: software clears battery flag after seconds write
// RULE16: results reported in control-2 at Fh
// RULE17: sampling second follows internal seconds tick
`timescale 1ns/1ps
module rtc_supply_osc_status_detect #(
	parameter int SAMPLE_CYCLES = rtc_detect_pkg::BAT_SAMPLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire rtc_detect_pkg::reg_req_t reg_req,
	input wire rtc_detect_pkg::det_pins_t det_pins,
	input wire rtc_detect_pkg::flag_evt_t flag_evt,
	input wire logic sec_tick,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [7:0] digital_offset,
	output logic [7:0] control_one,
	output logic [7:0] control_two_status,
	output logic regs_clear,
	output logic bat_monitor_en,
	output logic int_wk_o,
	output logic int_wk_oe,
	output logic int_mo_o,
	output logic int_mo_oe
);
	rtc_detect_pkg::det_pins_t det_s;
	rtc_detect_pkg::mon_state_t state;
	rtc_detect_pkg::mon_state_t next_state;
	logic [rtc_detect_pkg::SAMPLE_CNT_W-1:0] sample_cnt;
	logic [rtc_detect_pkg::SAMPLE_CNT_W-1:0] next_sample_cnt;
	logic [rtc_detect_pkg::SAMPLE_CNT_W-1:0] sample_last;
	logic [7:0] next_offset;
	logic [7:0] next_ctrl1;
	logic [7:0] next_ctrl2;
	logic [7:0] clr_vec;
	logic [7:0] set_vec;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic next_wk_oe;
	logic next_mo_oe;
	logic pon_active;
	logic wr_c2;
	logic bat_set;

	assign sample_last = rtc_detect_pkg::SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
	assign wr_c2 = reg_req.wr && (reg_req.addr == rtc_detect_pkg::ADDR_CONTROL_TWO_STATUS);
	// a stored flag or a fresh detection both hold the forced state
	assign pon_active = control_two_status[rtc_detect_pkg::C2_POWER_ON] || det_s.por;
	assign bat_set = (state == rtc_detect_pkg::MON_SAMPLE) && det_s.bat_low
		&& !control_two_status[rtc_detect_pkg::C2_BATTERY_DROP];

	sync_two_flop #(
		.WIDTH(3)
	) u_det_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(det_pins),
		.sync_out(det_s)
	);

	// battery monitor scheduling
	always_comb
	begin
		next_state = state;
		next_sample_cnt = sample_cnt;
		case (state)
			rtc_detect_pkg::MON_IDLE:
			begin
				next_sample_cnt = '0;
				if (sec_tick && !control_two_status[rtc_detect_pkg::C2_BATTERY_DROP]) // RULE13 RULE17
				begin
					next_state = rtc_detect_pkg::MON_SAMPLE;
				end
			end
			rtc_detect_pkg::MON_SAMPLE:
			begin
				if (control_two_status[rtc_detect_pkg::C2_BATTERY_DROP]) // RULE14
				begin
					next_state = rtc_detect_pkg::MON_IDLE;
				end
				else if (sample_cnt == sample_last) // RULE13
				begin
					next_state = rtc_detect_pkg::MON_IDLE;
				end
				else
				begin
					next_sample_cnt = sample_cnt + 1'b1;
				end
			end
			default:
			begin
				next_state = rtc_detect_pkg::MON_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= rtc_detect_pkg::MON_IDLE;
			sample_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			sample_cnt <= next_sample_cnt;
		end
	end

	// register file and status flags
	always_comb
	begin
		next_offset = digital_offset;
		next_ctrl1 = control_one;
		if (reg_req.wr && reg_req.addr == rtc_detect_pkg::ADDR_DIGITAL_OFFSET)
		begin
			next_offset = reg_req.wdata;
		end
		if (reg_req.wr && reg_req.addr == rtc_detect_pkg::ADDR_CONTROL_ONE)
		begin
			next_ctrl1 = reg_req.wdata & rtc_detect_pkg::C1_WRITE_MASK; // RULE7
		end
		// writing zero clears; the oscillator bit is outside the clear mask
		clr_vec = wr_c2 ? (~reg_req.wdata & rtc_detect_pkg::C2_CLEAR_MASK) : 8'h00; // RULE2 RULE10 RULE12
		set_vec = {flag_evt.bit7_hit, bat_set, 1'b0, det_s.por, flag_evt.event_hit,
			flag_evt.periodic_hit,
			flag_evt.weekly_match && control_one[rtc_detect_pkg::C1_WEEKLY_ALARM_ENABLE],
			flag_evt.monthly_match && control_one[rtc_detect_pkg::C1_MONTHLY_ALARM_ENABLE]};
		// set after clear so a same-cycle event is kept
		next_ctrl2 = (control_two_status & ~clr_vec) | set_vec; // RULE1 RULE3 RULE11 RULE16
		if (det_s.osc_stop)
		begin
			next_ctrl2[rtc_detect_pkg::C2_OSC_STOP] = 1'b0; // RULE9
		end
		if (pon_active)
		begin
			next_offset = rtc_detect_pkg::OFFSET_RESET; // RULE4
			next_ctrl1 = rtc_detect_pkg::C1_RESET; // RULE4
			next_ctrl2 = next_ctrl2 & ~rtc_detect_pkg::C2_FORCE_MASK; // RULE4
		end
		if (det_s.por)
		begin
			next_ctrl2 = rtc_detect_pkg::C2_RESET; // RULE6
		end
		next_rvalid = reg_req.rd;
		case (reg_req.addr)
			rtc_detect_pkg::ADDR_DIGITAL_OFFSET: next_rdata = digital_offset;
			rtc_detect_pkg::ADDR_CONTROL_ONE: next_rdata = control_one;
			rtc_detect_pkg::ADDR_CONTROL_TWO_STATUS: next_rdata = control_two_status; // RULE16
			default: next_rdata = 8'h00;
		endcase
		if (!reg_req.rd)
		begin
			next_rdata = reg_rdata;
		end
		// open-drain pins only ever pull low; power-on lets go of both
		next_wk_oe = control_two_status[rtc_detect_pkg::C2_WEEKLY_ALARM] && !pon_active; // RULE5
		next_mo_oe = control_two_status[rtc_detect_pkg::C2_MONTHLY_ALARM] && !pon_active; // RULE5
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			digital_offset <= rtc_detect_pkg::OFFSET_RESET;
			control_one <= rtc_detect_pkg::C1_RESET;
			control_two_status <= rtc_detect_pkg::C2_RESET;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			regs_clear <= 1'b1;
			int_wk_o <= 1'b0;
			int_wk_oe <= 1'b0;
			int_mo_o <= 1'b0;
			int_mo_oe <= 1'b0;
			bat_monitor_en <= 1'b0;
		end
		else
		begin
			digital_offset <= next_offset;
			control_one <= next_ctrl1;
			control_two_status <= next_ctrl2;
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
			regs_clear <= next_ctrl2[rtc_detect_pkg::C2_POWER_ON]; // RULE4
			int_wk_o <= 1'b0;
			int_wk_oe <= next_wk_oe;
			int_mo_o <= 1'b0;
			int_mo_oe <= next_mo_oe;
			bat_monitor_en <= (next_state == rtc_detect_pkg::MON_SAMPLE);
		end
	end

	property p_pon_set;
		@(posedge core_clk) disable iff (rst)
		det_s.por |=> control_two_status == rtc_detect_pkg::C2_RESET;
	endproperty
	a_pon_set: assert property (p_pon_set) else $error("power-on defaults not loaded"); // RULE1 RULE6

	property p_pon_hold;
		@(posedge core_clk) disable iff (rst)
		control_two_status[4] && !(wr_c2 && !reg_req.wdata[4]) |=> control_two_status[4];
	endproperty
	a_pon_hold: assert property (p_pon_hold) else $error("power-on flag dropped"); // RULE3

	property p_pon_clear;
		@(posedge core_clk) disable iff (rst)
		wr_c2 && !reg_req.wdata[4] && !det_s.por |=> !control_two_status[4];
	endproperty
	a_pon_clear: assert property (p_pon_clear) else $error("power-on flag not cleared"); // RULE2

	property p_force_zero;
		@(posedge core_clk) disable iff (rst)
		control_two_status[4] |-> control_one == 8'h00 && digital_offset == 8'h00
			&& (control_two_status & 8'h8f) == 8'h00 && regs_clear;
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("registers not forced"); // RULE4

	property p_int_release;
		@(posedge core_clk) disable iff (rst)
		control_two_status[4] |-> !int_wk_oe && !int_mo_oe;
	endproperty
	a_int_release: assert property (p_int_release) else $error("interrupt pin driven"); // RULE5

	property p_readonly_bit;
		@(posedge core_clk) disable iff (rst)
		reg_req.rd && reg_req.addr == 4'he |=> reg_rvalid && !reg_rdata[5];
	endproperty
	a_readonly_bit: assert property (p_readonly_bit) else $error("read-only bit set"); // RULE7

	property p_osc_clear;
		@(posedge core_clk) disable iff (rst)
		control_two_status[5] && det_s.osc_stop && !det_s.por |=> !control_two_status[5];
	endproperty
	a_osc_clear: assert property (p_osc_clear) else $error("oscillator flag not cleared"); // RULE9

	property p_osc_write;
		@(posedge core_clk) disable iff (rst)
		wr_c2 && !det_s.osc_stop && !det_s.por
			|=> control_two_status[5] == $past(control_two_status[5]);
	endproperty
	a_osc_write: assert property (p_osc_write) else $error("oscillator flag written"); // RULE10

	property p_bat_set;
		@(posedge core_clk) disable iff (rst)
		bat_set |=> control_two_status[6];
	endproperty
	a_bat_set: assert property (p_bat_set) else $error("battery flag not set"); // RULE11

	// only a zero written to bit 6 may drop the flag
	property p_bat_hold;
		@(posedge core_clk) disable iff (rst)
		control_two_status[6] && !(wr_c2 && !reg_req.wdata[6]) |=> control_two_status[6];
	endproperty
	a_bat_hold: assert property (p_bat_hold) else $error("battery flag dropped"); // RULE12

	property p_bat_clear;
		@(posedge core_clk) disable iff (rst)
		wr_c2 && !reg_req.wdata[6] && !bat_set && !det_s.por |=> !control_two_status[6];
	endproperty
	a_bat_clear: assert property (p_bat_clear) else $error("battery flag not cleared"); // RULE12

	property p_sample_stop;
		@(posedge core_clk) disable iff (rst)
		control_two_status[6] && state == rtc_detect_pkg::MON_SAMPLE |=> !bat_monitor_en;
	endproperty
	a_sample_stop: assert property (p_sample_stop) else $error("sampling not stopped"); // RULE14

	property p_window;
		@(posedge core_clk) disable iff (rst)
		state == rtc_detect_pkg::MON_SAMPLE |-> int'(sample_cnt) < SAMPLE_CYCLES && bat_monitor_en;
	endproperty
	a_window: assert property (p_window) else $error("sampling window overrun"); // RULE13

	property p_tick_start;
		@(posedge core_clk) disable iff (rst)
		sec_tick && state == rtc_detect_pkg::MON_IDLE && !control_two_status[6]
			|=> state == rtc_detect_pkg::MON_SAMPLE;
	endproperty
	a_tick_start: assert property (p_tick_start) else $error("sampling not started"); // RULE17

	c_pon_clear: cover property (@(posedge core_clk) disable iff (rst)
		control_two_status[4] ##1 !control_two_status[4]);
	c_bat_drop: cover property (@(posedge core_clk) disable iff (rst) bat_set);
	c_osc_stop: cover property (@(posedge core_clk) disable iff (rst)
		control_two_status[5] ##1 !control_two_status[5]);
	c_window_end: cover property (@(posedge core_clk) disable iff (rst)
		state == rtc_detect_pkg::MON_SAMPLE ##1 state == rtc_detect_pkg::MON_IDLE);
endmodule : rtc_supply_osc_status_detect

// >>> rtc_detect_pkg.sv
// shared constants and carrier types of the supply, oscillator and battery detection block
// assumes a single 40 MHz core clock and an internal 4-bit register port
package rtc_detect_pkg;

	// register offsets on the internal register port
	localparam logic [3:0] ADDR_DIGITAL_OFFSET = 4'h7;
	localparam logic [3:0] ADDR_CONTROL_ONE = 4'he;
	localparam logic [3:0] ADDR_CONTROL_TWO_STATUS = 4'hf;

	// control-2 field positions
	localparam int C2_BIT7_FLAG = 7;
	localparam int C2_BATTERY_DROP = 6;
	localparam int C2_OSC_STOP = 5;
	localparam int C2_POWER_ON = 4;
	localparam int C2_EVENT_DETECT = 3;
	localparam int C2_PERIODIC_IRQ = 2;
	localparam int C2_WEEKLY_ALARM = 1;
	localparam int C2_MONTHLY_ALARM = 0;

	// control-1 field positions
	localparam int C1_WEEKLY_ALARM_ENABLE = 7;
	localparam int C1_MONTHLY_ALARM_ENABLE = 6;
	localparam int C1_BIT5_READONLY = 5;

	// values after a power-on from zero volts
	localparam logic [7:0] C2_RESET = 8'h70;
	localparam logic [7:0] C1_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;

	// control-1 bit 5 is read-only zero; control-2 bits other than bit 5 cleared by writing zero
	localparam logic [7:0] C1_WRITE_MASK = 8'hdf;
	localparam logic [7:0] C2_CLEAR_MASK = 8'hdf;
	// bits held at zero while the power-on flag stands
	localparam logic [7:0] C2_FORCE_MASK = 8'h8f;

	// battery sampling window
	localparam real CLK_PERIOD_NS = 25.0;
	localparam real BAT_SAMPLE_MS = 7.8;
	localparam int BAT_SAMPLE_CYCLES = int'(BAT_SAMPLE_MS * 1000000.0 / CLK_PERIOD_NS);
	localparam int SAMPLE_CNT_W = 19;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// analog detector levels, asynchronous to core_clk
	typedef struct packed {
		logic por;
		logic osc_stop;
		logic bat_low;
	} det_pins_t;

	// flag sources from neighbouring timekeeping logic, same clock
	typedef struct packed {
		logic bit7_hit;
		logic event_hit;
		logic periodic_hit;
		logic weekly_match;
		logic monthly_match;
	} flag_evt_t;

	typedef enum logic [0:0] {
		MON_IDLE = 1'b0,
		MON_SAMPLE = 1'b1
	} mon_state_t;

endpackage : rtc_detect_pkg

// >>> sync_two_flop.sv
// two-flop synchroniser for asynchronous levels
// assumes the levels are quasi-static compared with core_clk
`timescale 1ns/1ps
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : sync_two_flop

// >>> test_rtc_supply_osc_status_detect.sv
// self-checking bench of the detection block, register port driven directly
// assumes 40 MHz core_clk, synchronous active-high rst, sampling window shortened to 16
`timescale 1ns/1ps
module test_rtc_supply_osc_status_detect;
	localparam int SC = 16;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	rtc_detect_pkg::reg_req_t reg_req = '0;
	rtc_detect_pkg::det_pins_t det_pins = '0;
	rtc_detect_pkg::flag_evt_t flag_evt = '0;
	logic sec_tick = 1'b0;
	logic [7:0] reg_rdata, digital_offset, control_one, control_two_status;
	logic reg_rvalid, regs_clear, bat_monitor_en, int_wk_o, int_wk_oe, int_mo_o, int_mo_oe;
	int fails = 0;
	int checks_done = 0;
	int len;
	// address, write data, read-back value
	logic [7:0] rows [6][3] = '{'{8'h07, 8'h55, 8'h55}, '{8'h07, 8'haa, 8'haa},
		'{8'h0e, 8'hff, 8'hdf}, '{8'h0e, 8'h00, 8'h00}, '{8'h0f, 8'hdf, 8'h20},
		'{8'h03, 8'hab, 8'h00}};

	rtc_supply_osc_status_detect #(.SAMPLE_CYCLES(SC)) rtc_supply_osc_status_detect_inst (
		.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .det_pins(det_pins),
		.flag_evt(flag_evt), .sec_tick(sec_tick), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .digital_offset(digital_offset), .control_one(control_one),
		.control_two_status(control_two_status), .regs_clear(regs_clear),
		.bat_monitor_en(bat_monitor_en), .int_wk_o(int_wk_o), .int_wk_oe(int_wk_oe),
		.int_mo_o(int_mo_o), .int_mo_oe(int_mo_oe));

	always #12.5 core_clk = ~core_clk;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge core_clk);
		reg_req.wr = 1'b0;
		@(negedge core_clk);
	endtask : wr

	// rvalid must stand exactly one cycle after the strobe
	task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge core_clk);
		reg_req.rd = 1'b0;
		chk("rvalid", 8'h01, {7'h00, reg_rvalid});
		chk(what, exp, reg_rdata);
		@(negedge core_clk);
	endtask : rdc

	// counts enable cycles over a span longer than one window
	task automatic window(output int n);
		sec_tick = 1'b1;
		@(negedge core_clk);
		sec_tick = 1'b0;
		n = 0;
		repeat (SC + 4)
		begin
			if (bat_monitor_en === 1'b1) n++;
			@(negedge core_clk);
		end
	endtask : window

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	initial
	begin
		#(25.0 * 3000);
		fails++;
		print_verdict();
	end

	initial
	begin
		cyc(3);
		rst = 1'b0;
		chk("c2 default", 8'h70, control_two_status);
		chk("c1 default", 8'h00, control_one);
		chk("offset default", 8'h00, digital_offset);
		chk("regs_clear", 8'h01, {7'h00, regs_clear});
		chk("oe idle", 8'h00, {6'h00, int_wk_oe, int_mo_oe});
		wr(4'h7, 8'h33);
		wr(4'hf, 8'hdf);
		chk("offset held", 8'h00, digital_offset);
		rdc("c2 ones ignored", 4'hf, 8'h70);
		wr(4'hf, 8'h00);
		rdc("c2 cleared", 4'hf, 8'h20);
		chk("regs_clear off", 8'h00, {7'h00, regs_clear});
		// offset, control-1 read-only bit, control-2 ones, unmapped address
		for (int r = 0; r < 6; r++)
		begin
			wr(rows[r][0][3:0], rows[r][1]);
			rdc("row", rows[r][0][3:0], rows[r][2]);
		end
		window(len);
		chk("window length", 8'(SC), 8'(len));
		det_pins.bat_low = 1'b1;
		cyc(4);
		window(len);
		chk("short window", 8'h01, {7'h00, len > 0 && len < SC});
		chk("bat flag", 8'h60, control_two_status);
		window(len);
		chk("no window", 8'h00, 8'(len));
		det_pins.bat_low = 1'b0;
		cyc(4);
		wr(4'hf, 8'hbf);
		rdc("bat cleared", 4'hf, 8'h20);
		window(len);
		chk("window again", 8'(SC), 8'(len));
		det_pins.osc_stop = 1'b1;
		cyc(4);
		det_pins.osc_stop = 1'b0;
		cyc(4);
		wr(4'hf, 8'hdf);
		rdc("osc flag", 4'hf, 8'h00);
		wr(4'he, 8'hc0);
		flag_evt = '1;
		@(negedge core_clk);
		flag_evt = '0;
		cyc(1);
		rdc("event flags", 4'hf, 8'h8f);
		chk("oe driven", 8'h03, {6'h00, int_wk_oe, int_mo_oe});
		chk("pin data", 8'h00, {6'h00, int_wk_o, int_mo_o});
		det_pins.por = 1'b1;
		cyc(4);
		det_pins.por = 1'b0;
		cyc(4);
		chk("por c2", 8'h70, control_two_status);
		chk("por c1", 8'h00, control_one);
		chk("por oe", 8'h00, {6'h00, int_wk_oe, int_mo_oe});
		chk("por clear", 8'h01, {7'h00, regs_clear});
		// a mid-run reset must behave as a fresh power-on
		wr(4'hf, 8'h00);
		wr(4'h7, 8'h12);
		chk("offset set", 8'h12, digital_offset);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk("rst c2", 8'h70, control_two_status);
		chk("rst offset", 8'h00, digital_offset);
		chk("rst clear", 8'h01, {7'h00, regs_clear});
		print_verdict();
	end
endmodule : test_rtc_supply_osc_status_detect
